// ### adc_ctrl_defines.svh
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define ADDR_CSR 4'h0
`define ADDR_RES_A 4'h1
`define ADDR_RES_B 4'h2
`define ADDR_RES_C 4'h3
`define ADDR_RES_D 4'h4
`define ADDR_IRQ_STAT 4'h5
`define ADDR_IRQ_MASK 4'h6

`define CSR_CHAN_LO 0
`define CSR_CHAN_HI 1
`define CSR_SCAN 4
`define CSR_START 5
`define CSR_IE 6
`define CSR_END 7

`define CSR_RESET 8'h00
`define RES_WIDTH 10
`define CONV_CYCLES 10
`define CMP_SETTLE 2

`endif

// ### adc_ctrl_pkg.sv
// Types shared by the converter control files
package adc_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_APPROX = 3'b100
   } conv_state_t;
endpackage : adc_ctrl_pkg

// ### adc_ctrl_properties.sv
// Port-level checks of the converter control
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"
module adc_ctrl_properties #(
   parameter int RES_W = 10,
   parameter int SAMPLE_CYCLES = 10
) (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic I_EXT_TRIG,
   input wire logic I_CMP_HIGH,
   input wire logic [RES_W-1:0] O_DAC_TRIAL,
   input wire logic [1:0] O_CHAN_SEL,
   input wire logic O_SAMPLE,
   input wire logic O_IRQ
);
   logic csr_wr;
   logic [7:0] cnt_r;
   logic [4:0] trig_r;
   logic start_r;
   logic halt_r;
   logic [1:0] chan_r;
   assign csr_wr = I_WR && I_ADDR == `ADDR_CSR;
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cnt_r <= 8'h00;
         trig_r <= 5'h00;
         start_r <= 1'b0;
         halt_r <= 1'b0;
         chan_r <= 2'h0;
      end else begin
         cnt_r <= O_SAMPLE ? cnt_r + 8'h01 : 8'h00;
         trig_r <= {trig_r[3:0], I_EXT_TRIG};
         start_r <= csr_wr && I_WDATA[`CSR_START];
         halt_r <= csr_wr && !I_WDATA[`CSR_START];
         chan_r <= I_WDATA[1:0];
      end
   end
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   sequence conv_go_s;
      $rose(O_SAMPLE) && start_r;
   endsequence
   sequence sample_end_s;
      $fell(O_SAMPLE) && !halt_r;
   endsequence
   rdata_quiet_a: assert property (
      !$past(I_RD) |-> O_RDATA == 16'h0000) else $error("stray read data");
   unmapped_rd_a: assert property (
      $past(I_RD) && $past(I_ADDR) > `ADDR_IRQ_MASK |-> O_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   sample_len_a: assert property (
      sample_end_s |-> cnt_r == SAMPLE_CYCLES) else $error("sample length");
   chan_hold_a: assert property (
      O_SAMPLE && $past(O_SAMPLE) |-> $stable(O_CHAN_SEL))
      else $error("channel moved while sampling");
   halt_now_a: assert property (
      halt_r && $past(O_SAMPLE) |-> !O_SAMPLE) else $error("halt ignored");
   sar_first_a: assert property (
      sample_end_s |-> ##[0:2] O_DAC_TRIAL == {1'b1, {(RES_W-1){1'b0}}})
      else $error("first trial not midscale");
   start_cause_a: assert property (
      $rose(O_SAMPLE) |-> start_r || |trig_r) else $error("start uncaused");
   start_chan_a: assert property (
      conv_go_s |-> O_CHAN_SEL == chan_r) else $error("wrong channel");
endmodule : adc_ctrl_properties
bind adc_single_mode_control adc_ctrl_properties #(.RES_W(RES_W),
   .SAMPLE_CYCLES(SAMPLE_CYCLES)) props (.I_SYS_CLK(I_SYS_CLK),
   .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
   .I_RD(I_RD), .O_RDATA(O_RDATA), .I_EXT_TRIG(I_EXT_TRIG),
   .I_CMP_HIGH(I_CMP_HIGH), .O_DAC_TRIAL(O_DAC_TRIAL),
   .O_CHAN_SEL(O_CHAN_SEL), .O_SAMPLE(O_SAMPLE), .O_IRQ(O_IRQ));

// ### adc_single_mode_control.sv
// Converter control: registers, start logic, sequencing and interrupt
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"
module adc_single_mode_control
   import adc_ctrl_pkg::*;
#(
   parameter int RES_W = `RES_WIDTH,
   parameter int SAMPLE_CYCLES = `CONV_CYCLES
) (
   input wire logic I_SYS_CLK,
   input wire logic I_NRST,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [15:0] O_RDATA,
   input wire logic I_EXT_TRIG,
   input wire logic I_CMP_HIGH,
   output logic [RES_W-1:0] O_DAC_TRIAL,
   output logic [1:0] O_CHAN_SEL,
   output logic O_SAMPLE,
   output logic O_IRQ
);
   logic rst_meta_r;
   logic rst_n_r;
   logic trig_meta_r;
   logic trig_sync_r;
   logic trig_prev_r;
   logic cmp_meta_r;
   logic cmp_sync_r;
   logic [1:0] chan_r;
   logic scan_r;
   logic conv_start_bit_r;
   logic conv_irq_enable_r;
   logic conv_end_flag_r;
   logic end_seen_r;
   logic [RES_W-1:0] result_r [4];
   logic [1:0] conv_chan_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [7:0] samp_cnt_r;
   conv_state_t state_r;
   logic trig_rise;
   logic csr_wr;
   logic start_req;
   logic halt_req;
   logic sar_go;
   logic sar_done;
   logic [RES_W-1:0] sar_value;
   logic conv_done_irq;
   logic stat_irq;
   logic csr_rd;
   logic conv_finish;
   logic [1:0] pace_cnt_r;
   logic sar_step;

   function automatic logic [15:0] pad_res(input logic [RES_W-1:0] v);
      pad_res = 16'(v);
   endfunction : pad_res

   // ********************
   // Reset and input synchronisers
   // ********************
   // Released through two flops so all logic leaves reset on one edge
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trig_meta_r <= 1'b0;
         trig_sync_r <= 1'b0;
         trig_prev_r <= 1'b0;
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
      end else begin
         trig_meta_r <= I_EXT_TRIG;
         trig_sync_r <= trig_meta_r;
         trig_prev_r <= trig_sync_r;
         cmp_meta_r <= I_CMP_HIGH;
         cmp_sync_r <= cmp_meta_r;
      end
   end

   assign trig_rise = trig_sync_r && !trig_prev_r;
   assign csr_wr = I_WR && (I_ADDR == `ADDR_CSR);
   assign csr_rd = I_RD && (I_ADDR == `ADDR_CSR);
   // The engine's done pulse only counts while a conversion is still owned
   assign conv_finish = sar_done && (state_r == ST_APPROX);
   // Writing start 1, or a trigger edge while idle, begins a conversion
   assign start_req = (csr_wr && I_WDATA[`CSR_START])
      || (trig_rise && state_r == ST_IDLE);
   assign halt_req = csr_wr && !I_WDATA[`CSR_START]
      && state_r != ST_IDLE;

   // ********************
   // Control and status register
   // ********************
   // Mode and channel follow the write even when start is set with them
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         chan_r <= 2'h0;
         scan_r <= 1'b0;
         conv_irq_enable_r <= 1'b0;
      end else if (csr_wr) begin
         chan_r <= I_WDATA[`CSR_CHAN_HI:`CSR_CHAN_LO];
         scan_r <= I_WDATA[`CSR_SCAN];
         conv_irq_enable_r <= I_WDATA[`CSR_IE];
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         conv_start_bit_r <= 1'b0;
      end else if (conv_finish) begin
         // Completion outranks a start in the same cycle, so busy always ends
         conv_start_bit_r <= 1'b0;
      end else if (start_req) begin
         conv_start_bit_r <= 1'b1;
      end else if (halt_req || csr_wr) begin
         conv_start_bit_r <= 1'b0;
      end
   end

   // Clear is armed only by a read that saw the flag set; set wins over clear
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         conv_end_flag_r <= 1'b0;
         end_seen_r <= 1'b0;
      end else begin
         if (csr_rd && conv_end_flag_r) begin
            end_seen_r <= 1'b1;
         end
         if (conv_finish) begin
            conv_end_flag_r <= 1'b1;
         end else if (csr_wr && !I_WDATA[`CSR_END] && end_seen_r) begin
            conv_end_flag_r <= 1'b0;
            end_seen_r <= 1'b0;
         end
      end
   end

   // ********************
   // Conversion sequencer
   // ********************
   // Sample phase holds the mux on the channel before approximation begins
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
         samp_cnt_r <= 8'h00;
         conv_chan_r <= 2'h0;
      end else if (halt_req) begin
         // The engine is aborted on the same edge, so no late result lands
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_req) begin
                  state_r <= ST_SAMPLE;
                  samp_cnt_r <= 8'(SAMPLE_CYCLES - 1);
                  conv_chan_r <= csr_wr ?
                     I_WDATA[`CSR_CHAN_HI:`CSR_CHAN_LO] : chan_r;
               end
            end
            ST_SAMPLE: begin
               if (samp_cnt_r == 8'h00) begin
                  state_r <= ST_APPROX;
               end else begin
                  samp_cnt_r <= samp_cnt_r - 8'h01;
               end
            end
            ST_APPROX: begin
               if (sar_done) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // The engine is started on the last sample cycle, not after it
   assign sar_go = (state_r == ST_SAMPLE) && (samp_cnt_r == 8'h00);

   // ********************
   // Bit pacing
   // ********************
   // The comparator answer crosses two synchroniser flops, so each trial
   // must stand for three cycles before its bit is decided. This divider
   // makes the one-cycle decide pulse; it costs speed but not accuracy.
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pace_cnt_r <= 2'h0;
      end else if (state_r != ST_APPROX || sar_step) begin
         pace_cnt_r <= 2'(`CMP_SETTLE);
      end else begin
         pace_cnt_r <= pace_cnt_r - 2'h1;
      end
   end

   assign sar_step = (state_r == ST_APPROX) && (pace_cnt_r == 2'h0);

   sar_engine #(
      .WIDTH(RES_W)
   ) u_sar (
      .i_clk(I_SYS_CLK),
      .i_rst_n(rst_n_r),
      .i_go(sar_go),
      .i_step(sar_step),
      .i_abort(halt_req),
      .i_cmp_high(cmp_sync_r),
      .o_trial(O_DAC_TRIAL),
      .o_value(sar_value),
      .o_done(sar_done)
   );

   // ********************
   // Result registers
   // ********************
   // Each channel lands in its own register; input 1 goes to register B
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int i = 0; i < 4; i++) begin
            result_r[i] <= '0;
         end
      end else if (conv_finish) begin
         // Other channels keep their last result until converted again
         result_r[conv_chan_r] <= sar_value;
      end
   end

   // ********************
   // Interrupt status and mask
   // ********************
   // Bit 0 completion, bit 1 halted; write one to clear, set wins
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
      end else begin
         if (I_WR && I_ADDR == `ADDR_IRQ_MASK) begin
            irq_mask_r <= I_WDATA[1:0];
         end
         irq_stat_r <= (irq_stat_r
            & ~((I_WR && I_ADDR == `ADDR_IRQ_STAT) ? I_WDATA[1:0] : 2'h0))
            | {halt_req, conv_finish};
      end
   end

   assign conv_done_irq = conv_end_flag_r && conv_irq_enable_r;
   // Either source alone holds the line; both must be cleared to drop it
   assign stat_irq = |(irq_stat_r & irq_mask_r);
   assign O_IRQ = conv_done_irq || stat_irq;

   // ********************
   // Read port
   // ********************
   // Data stands one cycle and then returns to zero, so idle reads are quiet
   always_ff @(posedge I_SYS_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         O_RDATA <= 16'h0000;
      end else if (I_RD) begin
         case (I_ADDR)
            `ADDR_CSR: O_RDATA <= {8'h00, conv_end_flag_r,
               conv_irq_enable_r, conv_start_bit_r, scan_r, 2'h0,
               chan_r};
            `ADDR_RES_A: O_RDATA <= pad_res(result_r[0]);
            `ADDR_RES_B: O_RDATA <= pad_res(result_r[1]);
            `ADDR_RES_C: O_RDATA <= pad_res(result_r[2]);
            `ADDR_RES_D: O_RDATA <= pad_res(result_r[3]);
            `ADDR_IRQ_STAT: O_RDATA <= {14'h0000, irq_stat_r};
            `ADDR_IRQ_MASK: O_RDATA <= {14'h0000, irq_mask_r};
            default: O_RDATA <= 16'h0000;
         endcase
      end else begin
         O_RDATA <= 16'h0000;
      end
   end

   assign O_CHAN_SEL = conv_chan_r;
   assign O_SAMPLE = (state_r == ST_SAMPLE);
endmodule : adc_single_mode_control

// ### adc_single_mode_control_test.sv
// Self-checking bench for the converter control
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"
module adc_single_mode_control_test;
   localparam logic [39:0] LV = {10'h3FF, 10'h0C3, 10'h2A7, 10'h155};
   logic clk, nrst, wr, rd, trig, cmp, samp, irq;
   logic [3:0] addr;
   logic [7:0] wd;
   logic [15:0] rdat;
   logic [9:0] trial;
   logic [1:0] chan;
   int err_count, samples_checked, cyc;
   adc_single_mode_control #(.SAMPLE_CYCLES(4)) dut (.I_SYS_CLK(clk),
      .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
      .O_RDATA(rdat), .I_EXT_TRIG(trig), .I_CMP_HIGH(cmp),
      .O_DAC_TRIAL(trial), .O_CHAN_SEL(chan), .O_SAMPLE(samp), .O_IRQ(irq));
   cmp_front_model fe (.i_trial(trial), .i_chan(chan), .i_levels(LV),
      .o_cmp_high(cmp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         close_out();
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task rd_chk(input logic [3:0] a, input logic [15:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, e);
      @(posedge clk);
   endtask : rd_chk
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk(16'(irq), 16'h0001);
      @(posedge clk);
   endtask : wait_irq
   task t_reset;
      rd_chk(`ADDR_CSR, 16'h0000);
      rd_chk(4'hF, 16'h0000);
      $display("reset test done");
   endtask : t_reset
   task t_single;
      wr_reg(`ADDR_CSR, 8'h61);
      chk(16'(chan), 16'h0001);
      chk(16'(samp), 16'h0001);
      rd_chk(`ADDR_CSR, 16'h0061);
      wait_irq();
      rd_chk(`ADDR_CSR, 16'h00C1);
      rd_chk(`ADDR_RES_B, 16'(LV[19:10]));
      rd_chk(`ADDR_RES_A, 16'h0000);
      $display("single test done");
   endtask : t_single
   task t_flag;
      wr_reg(`ADDR_CSR, 8'h41);
      rd_chk(`ADDR_CSR, 16'h0041);
      chk(16'(irq), 16'h0000);
      wr_reg(`ADDR_CSR, 8'h61);
      wait_irq();
      wr_reg(`ADDR_CSR, 8'h41);
      rd_chk(`ADDR_CSR, 16'h00C1);
      wr_reg(`ADDR_CSR, 8'h41);
      rd_chk(`ADDR_CSR, 16'h0041);
      $display("flag test done");
   endtask : t_flag
   task t_halt;
      wr_reg(`ADDR_CSR, 8'h61);
      wr_reg(`ADDR_CSR, 8'h41);
      rd_chk(`ADDR_CSR, 16'h0041);
      wr_reg(`ADDR_CSR, 8'h62);
      wait_irq();
      rd_chk(`ADDR_RES_C, 16'(LV[29:20]));
      rd_chk(`ADDR_CSR, 16'h00C2);
      wr_reg(`ADDR_CSR, 8'h41);
      $display("halt test done");
   endtask : t_halt
   task t_trig;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(`ADDR_CSR, 16'h0061);
      wait_irq();
      rd_chk(`ADDR_RES_B, 16'(LV[19:10]));
      rd_chk(`ADDR_CSR, 16'h00C1);
      wr_reg(`ADDR_CSR, 8'h01);
      $display("trigger test done");
   endtask : t_trig
   task t_irq;
      wr_reg(`ADDR_IRQ_STAT, 8'h03);
      wr_reg(`ADDR_IRQ_MASK, 8'h01);
      chk(16'(irq), 16'h0000);
      wr_reg(`ADDR_CSR, 8'h21);
      wait_irq();
      wr_reg(`ADDR_IRQ_MASK, 8'h00);
      chk(16'(irq), 16'h0000);
      wr_reg(`ADDR_IRQ_MASK, 8'h01);
      chk(16'(irq), 16'h0001);
      wr_reg(`ADDR_IRQ_STAT, 8'h01);
      chk(16'(irq), 16'h0000);
      rd_chk(`ADDR_IRQ_STAT, 16'h0000);
      $display("interrupt test done");
   endtask : t_irq
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      trig = 1'b0;
      addr = 4'h0;
      wd = 8'h00;
      cyc = 0;
      err_count = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_single();
      t_flag();
      t_halt();
      t_trig();
      t_irq();
      close_out();
   end
endmodule : adc_single_mode_control_test

// ### cmp_front_model.sv
// Comparator model of the analog front end
`timescale 1ns/100ps
module cmp_front_model (
   input wire logic [9:0] i_trial,
   input wire logic [1:0] i_chan,
   input wire logic [39:0] i_levels,
   output logic o_cmp_high
);
   logic [9:0] lvl;
   assign lvl = i_levels[i_chan*10 +: 10];
   // Held input never moves, so a correct search lands on it exactly
   assign o_cmp_high = i_trial > lvl;
endmodule : cmp_front_model

// ### sar_engine.sv
// Successive-approximation bit search against the comparator input
`timescale 1ns/100ps
module sar_engine #(
   parameter int WIDTH = 10
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic i_step,
   input wire logic i_abort,
   input wire logic i_cmp_high,
   output logic [WIDTH-1:0] o_trial,
   output logic [WIDTH-1:0] o_value,
   output logic o_done
);
   logic [WIDTH-1:0] mask_r;
   logic [WIDTH-1:0] trial_r;
   logic busy_r;

   assign o_trial = trial_r;

   // One bit decided per step pulse, starting from the MSB
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_r <= '0;
         trial_r <= '0;
         busy_r <= 1'b0;
         o_value <= '0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_abort) begin
            busy_r <= 1'b0;
            trial_r <= '0;
         end else if (i_go && !busy_r) begin
            busy_r <= 1'b1;
            mask_r <= {1'b1, {(WIDTH-1){1'b0}}};
            trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
         end else if (busy_r && i_step) begin
            if (mask_r == {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               o_done <= 1'b1;
               o_value <= i_cmp_high ? (trial_r & ~mask_r) : trial_r;
            end else begin
               trial_r <= (i_cmp_high ? (trial_r & ~mask_r) : trial_r)
                  | (mask_r >> 1);
               mask_r <= mask_r >> 1;
            end
         end
      end
   end
endmodule : sar_engine
